// file: design/spp_pkg.sv
// Constants, types and register map of the parallel slave port
package spp_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam int          ADDR_W   = 8;
  localparam logic [7:0]  OFS_DATA = 8'h08;   // parallel_data_port
  localparam logic [7:0]  OFS_CTL  = 8'h09;   // control_pin_port
  localparam logic [7:0]  OFS_IRQF = 8'h0c;   // peripheral_irq_flags
  localparam logic [7:0]  OFS_DDIR = 8'h88;   // data_port_direction
  localparam logic [7:0]  OFS_STAT = 8'h89;   // slave_port_status_direction
  localparam logic [7:0]  OFS_IRQE = 8'h8c;   // peripheral_irq_enables
  localparam logic [7:0]  OFS_ANA  = 8'h9f;   // analog_pin_config

  // ----------------------------------------------------------------
  // Field positions, masks and reset values
  // ----------------------------------------------------------------
  localparam int          BIT_IBF  = 7;
  localparam int          BIT_OBF  = 6;
  localparam int          BIT_OVR  = 5;
  localparam int          BIT_SEL  = 4;
  localparam int          BIT_IRQ  = 7;
  localparam logic [2:0]  RST_CDIR = 3'h7;    // Control pins start as inputs
  localparam logic [7:0]  RST_DDIR = 8'hff;   // Data pins start as inputs
  localparam logic [7:0]  RST_ZERO = 8'h00;
  localparam logic [7:0]  ANA_MASK = 8'hcf;   // Bits 5:4 unimplemented
  localparam logic [7:0]  IRQ_MASK = 8'h7f;   // All but the slave-port flag

  // ----------------------------------------------------------------
  // Four-phase instruction clock
  // ----------------------------------------------------------------
  localparam logic [1:0]  PH_TWO   = 2'h1;
  localparam logic [1:0]  PH_FOUR  = 2'h3;
  localparam logic [1:0]  PH_STEP  = 2'h1;

  // Host control pins, in pin bit order
  typedef struct packed {
    logic cs_n;
    logic wr_n;
    logic rd_n;
  } spp_ctl_t;

  // Completion sequencer
  typedef enum logic [1:0] {
    SPP_IDLE      = 2'b00,
    SPP_WAIT_TWO  = 2'b01,
    SPP_WAIT_FOUR = 2'b10
  } spp_done_t;

endpackage

// file: design/spp_port.sv
// Parallel slave port: host latches, status flags, control pins
//
// Function
// - Select bit turns data port into slave port
// - Control pins become read, write, select strobes
// - One address: write output latch, read input
// - Slave mode ignores data-port direction register
// - Host write latches byte while both low and input not full
// - Write end sets full and irq flags
// - Only firmware data read or mode off clears input full
// - Write while full sets sticky overrun flag
// - Read start clears output full at once
// - Output latch driven while read selected
// - Read end sets irq flag on phase four
// - Firmware data write sets output full again
// - Mode off forces both full flags clear
// - Irq flag sticky, enable bit masks request
// - Select high means strobes are ignored
// - Status register resets to zero, direction ones
// - Control port holds three bits, rest zero
`timescale 1ns/1ps
`default_nettype none

module spp_port
  import spp_pkg::*;
#(
  parameter int PORT_W = 8
)(
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [7:0]        wdata,
  input  wire logic              wr_stb,
  input  wire logic              rd_stb,
  output logic      [7:0]        rdata,
  input  wire logic [PORT_W-1:0] data_pin_in,
  output logic      [PORT_W-1:0] data_pin_out,
  output logic      [PORT_W-1:0] data_pin_oe,
  input  wire spp_ctl_t          ctl_pin_in,
  output logic      [2:0]        ctl_pin_out,
  output logic      [2:0]        ctl_pin_oe,
  output logic                   slave_port_irq
);
  // Elaboration check: latches and pin drivers are byte wide only
  if (PORT_W != 8)
  begin : g_width_check
    $error("spp_port serves an 8-bit data port only");
  end
  // ----------------------------------------------------------------
  // Registers and internal state
  // ----------------------------------------------------------------
  logic [7:0]  out_latch;
  logic [7:0]  in_latch;
  logic [7:0]  data_port_direction;
  logic [2:0]  ctl_latch;
  logic [2:0]  ctl_dir;
  logic        slave_port_select;
  logic        input_full_flag;
  logic        output_full_flag;
  logic        input_overrun_flag;
  logic [7:0]  irq_flags;
  logic [7:0]  irq_enables;
  logic [7:0]  analog_pin_config;
  logic [1:0]  phase;
  spp_ctl_t    ctl_s1;
  spp_ctl_t    ctl_s2;
  logic [7:0]  data_s1;
  logic [7:0]  data_s2;
  logic        wr_act_q;
  logic        rd_act_q;
  logic        done_is_wr;
  spp_done_t   done_st;
  spp_done_t   next_done_st;
  // Decoded firmware accesses
  wire fw_wr_data = wr_stb && (addr == OFS_DATA);
  wire fw_rd_data = rd_stb && (addr == OFS_DATA);
  wire fw_wr_stat = wr_stb && (addr == OFS_STAT);
  wire fw_wr_irqf = wr_stb && (addr == OFS_IRQF);
  // Phase enables of the divided instruction clock
  wire ph_two  = (phase == PH_TWO);
  wire ph_four = (phase == PH_FOUR);
  // Synchronised strobe levels; select high masks both strobes
  wire wr_act = slave_port_select && !ctl_s2.cs_n && !ctl_s2.wr_n;
  wire rd_act = slave_port_select && !ctl_s2.cs_n && !ctl_s2.rd_n;
  // Start and end of host transfers
  wire wr_start = wr_act && !wr_act_q;
  wire wr_end   = !wr_act && wr_act_q;
  wire rd_start = rd_act && !rd_act_q;
  wire rd_end   = !rd_act && rd_act_q;
  wire set_done = (done_st == SPP_WAIT_FOUR) && ph_four;
  // Phase divider: one of four enables per system clock
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      phase <= 2'h0;
    else
      phase <= phase + PH_STEP;
  end
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Host strobes are asynchronous; only the second stage is read
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctl_s1  <= '1;
      ctl_s2  <= '1;
      data_s1 <= RST_ZERO;
      data_s2 <= RST_ZERO;
    end
    else
    begin
      ctl_s1  <= ctl_pin_in;
      ctl_s2  <= ctl_s1;
      data_s1 <= data_pin_in;
      data_s2 <= data_s1;
    end
  end
  // Previous strobe levels for edge detection
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_act_q <= 1'b0;
      rd_act_q <= 1'b0;
    end
    else
    begin
      wr_act_q <= wr_act;
      rd_act_q <= rd_act;
    end
  end
  // ----------------------------------------------------------------
  // Completion sequencer: wait next phase two, then phase four
  // ----------------------------------------------------------------
  always_comb
  begin
    next_done_st = done_st;
    unique case (done_st)
      SPP_IDLE:
        if (wr_end || rd_end)
          next_done_st = SPP_WAIT_TWO;
      SPP_WAIT_TWO:
        if (ph_two)
          next_done_st = SPP_WAIT_FOUR;
      SPP_WAIT_FOUR:
        if (ph_four)
          next_done_st = SPP_IDLE;
      default:
        next_done_st = SPP_IDLE;
    endcase
  end
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      done_st    <= SPP_IDLE;
      done_is_wr <= 1'b0;
    end
    else
    begin
      done_st <= next_done_st;
      if (done_st == SPP_IDLE && (wr_end || rd_end))
        done_is_wr <= wr_end;
    end
  end
  // ----------------------------------------------------------------
  // Host data latches
  // ----------------------------------------------------------------
  // Unread byte is kept on overrun, so firmware never sees a torn value
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      in_latch <= RST_ZERO;
    else if (wr_act && !input_full_flag)
      in_latch <= data_s2;
  end
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      out_latch <= RST_ZERO;
    else if (fw_wr_data)
      out_latch <= wdata;
  end
  // ----------------------------------------------------------------
  // Status flags; a hardware set wins over a same-cycle firmware clear
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      input_full_flag <= 1'b0;
    else if (!slave_port_select)
      input_full_flag <= 1'b0;
    else if (set_done && done_is_wr)
      input_full_flag <= 1'b1;
    else if (fw_rd_data)
      input_full_flag <= 1'b0;
  end
  // Firmware write wins over a host read start in the same cycle
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      output_full_flag <= 1'b0;
    else if (!slave_port_select)
      output_full_flag <= 1'b0;
    else if (fw_wr_data)
      output_full_flag <= 1'b1;
    else if (rd_start)
      output_full_flag <= 1'b0;
  end
  // Overrun has no mode-off clear; a status write loads it from bit 5 unless an overrun sets it that cycle
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      input_overrun_flag <= 1'b0;
    else if (wr_start && input_full_flag)
      input_overrun_flag <= 1'b1;
    else if (fw_wr_stat)
      input_overrun_flag <= wdata[BIT_OVR];
  end
  // Mode select and control pin directions
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      slave_port_select <= 1'b0;
      ctl_dir           <= RST_CDIR;
    end
    else if (fw_wr_stat)
    begin
      slave_port_select <= wdata[BIT_SEL];
      ctl_dir           <= wdata[2:0];
    end
  end
  // ----------------------------------------------------------------
  // Interrupt flags and enables
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      irq_flags <= RST_ZERO;
    else
    begin
      if (fw_wr_irqf)
        irq_flags <= wdata;
      if (set_done)
        irq_flags[BIT_IRQ] <= 1'b1;
    end
  end
  // Plain stored registers
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      irq_enables         <= RST_ZERO;
      analog_pin_config   <= RST_ZERO;
      data_port_direction <= RST_DDIR;
      ctl_latch           <= 3'h0;
    end
    else if (wr_stb)
    begin
      if (addr == OFS_IRQE)
        irq_enables <= wdata;
      if (addr == OFS_ANA)
        analog_pin_config <= wdata & ANA_MASK;
      if (addr == OFS_DDIR)
        data_port_direction <= wdata;
      if (addr == OFS_CTL)
        ctl_latch <= wdata[2:0];
    end
  end
  // Masked request, registered for a clean output
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      slave_port_irq <= 1'b0;
    else
      slave_port_irq <= irq_flags[BIT_IRQ] && irq_enables[BIT_IRQ];
  end
  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  // In slave mode only the host read strobe turns the data pins round
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      data_pin_out <= RST_ZERO;
      data_pin_oe  <= RST_ZERO;
    end
    else
    begin
      data_pin_out <= out_latch;
      if (slave_port_select)
        data_pin_oe <= {PORT_W{rd_act}};
      else
        data_pin_oe <= ~data_port_direction;
    end
  end
  // Strobe pins are never driven in slave mode, whatever the direction bits
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctl_pin_out <= 3'h0;
      ctl_pin_oe  <= 3'h0;
    end
    else
    begin
      ctl_pin_out <= ctl_latch;
      ctl_pin_oe  <= slave_port_select ? 3'h0 : ~ctl_dir;
    end
  end
  // ----------------------------------------------------------------
  // Read data, one cycle after the strobe
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      rdata <= RST_ZERO;
    else if (rd_stb)
    begin
      unique case (addr)
        OFS_DATA: rdata <= slave_port_select ? in_latch : data_s2;
        OFS_CTL:  rdata <= {5'h00, ctl_s2};
        OFS_IRQF: rdata <= irq_flags;
        OFS_DDIR: rdata <= data_port_direction;
        OFS_STAT: rdata <= {input_full_flag, output_full_flag, input_overrun_flag,
                            slave_port_select, 1'b0, ctl_dir};
        OFS_IRQE: rdata <= irq_enables;
        OFS_ANA:  rdata <= analog_pin_config;
        default:  rdata <= RST_ZERO;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence s_wr_done;
    wr_end && done_st == SPP_IDLE;
  endsequence
  sequence s_rd_done;
    rd_end && done_st == SPP_IDLE;
  endsequence
  property p_ibf_set;
    s_wr_done ##1 !fw_rd_data [*8] |-> input_full_flag || !slave_port_select;
  endproperty
  a_ibf_set: assert property (p_ibf_set) else $error("input full not set after write");
  property p_ibf_phase;
    $rose(input_full_flag) |-> $past(phase) == PH_FOUR;
  endproperty
  a_ibf_phase: assert property (p_ibf_phase) else $error("input full set off phase four");
  // End seen at k: phase two falls in k+1..k+4, flag visible k+4..k+7
  property p_irq_read;
    s_rd_done |-> ##[4:7] irq_flags[BIT_IRQ];
  endproperty
  a_irq_read: assert property (p_irq_read) else $error("irq flag not set after read");
  property p_ibf_clear;
    $fell(input_full_flag) |-> $past(fw_rd_data) || !$past(slave_port_select);
  endproperty
  a_ibf_clear: assert property (p_ibf_clear) else $error("input full cleared wrongly");
  property p_overrun;
    wr_start && input_full_flag |=> input_overrun_flag;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged");
  property p_obf_clear;
    rd_start && !fw_wr_data |=> !output_full_flag;
  endproperty
  a_obf_clear: assert property (p_obf_clear) else $error("output full not cleared");
  property p_obf_set;
    fw_wr_data && slave_port_select |=> output_full_flag;
  endproperty
  a_obf_set: assert property (p_obf_set) else $error("output full not set");
  property p_drive;
    rd_act |=> data_pin_oe == '1 && data_pin_out == $past(out_latch);
  endproperty
  a_drive: assert property (p_drive) else $error("output latch not driven");
  property p_mode_off;
    !slave_port_select |=> !input_full_flag && !output_full_flag;
  endproperty
  a_mode_off: assert property (p_mode_off) else $error("full flags not held clear");
  property p_irq_sticky;
    irq_flags[BIT_IRQ] && !fw_wr_irqf |=> irq_flags[BIT_IRQ];
  endproperty
  a_irq_sticky: assert property (p_irq_sticky) else $error("irq flag dropped");
  property p_irq_out;
    ##1 slave_port_irq == $past(irq_flags[BIT_IRQ] && irq_enables[BIT_IRQ]);
  endproperty
  a_irq_out: assert property (p_irq_out) else $error("irq request mismatch");
  property p_stat_bit3;
    rd_stb && addr == OFS_STAT |=> !rdata[3];
  endproperty
  a_stat_bit3: assert property (p_stat_bit3) else $error("status bit 3 not zero");
endmodule

`default_nettype wire

// file: dv/spp_host_model.sv
// Host microprocessor model driving the slave port pins
`timescale 1ns/1ps
`default_nettype none

module spp_host_model
  import spp_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic [7:0] data_pin_out,
  input  wire logic [7:0] data_pin_oe,
  output logic      [7:0] data_pin_in,
  output var spp_ctl_t    ctl_pin_in,
  output logic            rd_seen,
  output logic      [7:0] rd_byte
);
  logic       cs_n;
  logic       wr_n;
  logic       rd_n;
  logic       drv;
  logic [7:0] hd;
  logic [7:0] pat = 8'h3c;

  // Idle strobes high from time zero, as the synchroniser expects
  initial
  begin
    cs_n    = 1'b1;
    wr_n    = 1'b1;
    rd_n    = 1'b1;
    drv     = 1'b0;
    hd      = 8'h00;
    rd_seen = 1'b0;
    rd_byte = 8'h00;
  end

  // Released bus wanders every cycle so a stale byte never matches by luck
  always @(posedge sys_clk)
    pat <= pat + 8'h35;

  // Wire level: device enable wins, else host data, else wander
  assign data_pin_in = (data_pin_oe & data_pin_out) | (~data_pin_oe & (drv ? hd : pat));
  assign ctl_pin_in  = spp_ctl_t'({cs_n, wr_n, rd_n});

  // Host write: byte stays on the wire past the strobe rise
  task automatic host_write(input logic [7:0] d, input logic sel_n);
    @(posedge sys_clk);
    cs_n <= sel_n;
    wr_n <= 1'b0;
    hd   <= d;
    drv  <= 1'b1;
    repeat (4) @(posedge sys_clk);
    cs_n <= 1'b1;
    wr_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    drv  <= 1'b0;
  endtask

  // Host read: wait a bounded time for the device to drive, then sample
  task automatic host_read();
    int i;
    @(posedge sys_clk);
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    for (i = 0; i < 8 && data_pin_oe !== 8'hff; i++)
      @(posedge sys_clk);
    @(posedge sys_clk);
    rd_byte <= data_pin_in;
    rd_seen <= 1'b1;
    @(posedge sys_clk);
    rd_seen <= 1'b0;
    cs_n    <= 1'b1;
    rd_n    <= 1'b1;
  endtask
endmodule

`default_nettype wire

// file: dv/tb.sv
// Self-checking bench for the parallel slave port
`timescale 1ns/1ps
`default_nettype none

module tb
  import spp_pkg::*;
();
  // --------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------
  logic       sys_clk;
  logic       nrst;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr_stb;
  logic       rd_stb;
  logic [7:0] rdata;
  logic [7:0] data_pin_in;
  logic [7:0] data_pin_out;
  logic [7:0] data_pin_oe;
  spp_ctl_t   ctl_pin_in;
  logic [2:0] ctl_pin_out;
  logic [2:0] ctl_pin_oe;
  logic       slave_port_irq;
  logic       rd_seen;
  logic [7:0] rd_byte;
  logic       rd_q = 1'b0;
  logic [31:0] seed;
  logic [7:0] exp_reg_q[$];
  logic [7:0] exp_host_q[$];
  int         n_errors;
  int         cmp_count;

  spp_port #(.PORT_W(8)) spp_port_i (.sys_clk(sys_clk), .nrst(nrst), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .data_pin_in(data_pin_in), .data_pin_out(data_pin_out), .data_pin_oe(data_pin_oe),
    .ctl_pin_in(ctl_pin_in), .ctl_pin_out(ctl_pin_out), .ctl_pin_oe(ctl_pin_oe),
    .slave_port_irq(slave_port_irq));

  spp_host_model host_i (.sys_clk(sys_clk), .data_pin_out(data_pin_out),
    .data_pin_oe(data_pin_oe), .data_pin_in(data_pin_in), .ctl_pin_in(ctl_pin_in),
    .rd_seen(rd_seen), .rd_byte(rd_byte));

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic tally(input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic cmp_reg(input logic [7:0] e, input logic [7:0] g);
    tally(e, g);
  endtask

  task automatic cmp_host(input logic [7:0] e, input logic [7:0] g);
    tally(e, g);
  endtask

  task automatic cmp_lvl(input logic [7:0] e, input logic [7:0] g);
    tally(e, g);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Register bus: one-cycle strobes, changed just after the edge
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge sys_clk);
    wr_stb <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    addr   <= a;
    rd_stb <= 1'b1;
    exp_reg_q.push_back(e);
    @(posedge sys_clk);
    rd_stb <= 1'b0;
  endtask

  // Bounded wait for the interrupt level; running out ends the run
  task automatic wait_irq(input logic e);
    int i;
    for (i = 0; i < 16 && slave_port_irq !== e; i++)
      @(posedge sys_clk);
    if (i == 16)
    begin
      n_errors++;
      wrap_up();
    end
    else
      cmp_lvl({7'h00, e}, {7'h00, slave_port_irq});
  endtask

  // --------------------------------------------------------------
  // Result monitor: read data is checked in the cycle after the strobe
  // --------------------------------------------------------------
  always @(posedge sys_clk)
  begin
    if (rd_q)
      if (exp_reg_q.size() > 0)
        cmp_reg(exp_reg_q.pop_front(), rdata);
      else
        n_errors++;
    if (rd_seen)
      if (exp_host_q.size() > 0)
        cmp_host(exp_host_q.pop_front(), rd_byte);
      else
        n_errors++;
    rd_q <= rd_stb;
  end

  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // Hang guard
  initial
  begin
    #400000;
    n_errors++;
    wrap_up();
  end

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial
  begin
    nrst      = 1'b0;
    addr      = 8'h00;
    wdata     = 8'h00;
    wr_stb    = 1'b0;
    rd_stb    = 1'b0;
    seed      = 32'h1fe5b4b6;
    n_errors  = 0;
    cmp_count = 0;
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    // Reset values, pin readback and an unmapped address
    reg_rd(OFS_STAT, 8'h07);
    reg_rd(OFS_IRQF, 8'h00);
    reg_rd(OFS_IRQE, 8'h00);
    reg_rd(OFS_ANA, 8'h00);
    reg_rd(OFS_DDIR, 8'hff);
    reg_rd(OFS_CTL, 8'h07);
    reg_wr(8'h55, 8'hff);
    reg_rd(8'h55, 8'h00);
    $display("test reset_values done");
    // Setup: read-only flags, digital control pins, slave mode on
    reg_wr(OFS_ANA, 8'hff);
    reg_rd(OFS_ANA, 8'hcf);
    reg_wr(OFS_ANA, 8'h06);
    reg_wr(OFS_STAT, 8'hff);
    reg_rd(OFS_STAT, 8'h37);
    reg_wr(OFS_STAT, 8'h17);
    reg_rd(OFS_STAT, 8'h17);
    reg_wr(OFS_IRQE, 8'h80);
    reg_wr(OFS_CTL, 8'h05);
    reg_wr(OFS_DDIR, 8'h00);
    repeat (2) @(posedge sys_clk);
    cmp_lvl(8'h05, {5'h00, ctl_pin_out});
    cmp_lvl(8'h00, {5'h00, ctl_pin_oe});
    cmp_lvl(8'h00, data_pin_oe);
    $display("test setup done");
    // Both directions with random bytes
    for (int i = 0; i < 3; i++)
    begin
      seed = lfsr(seed);
      reg_wr(OFS_DATA, seed[7:0]);
      reg_rd(OFS_STAT, 8'h57);
      exp_host_q.push_back(seed[7:0]);
      host_i.host_read();
      wait_irq(1'b1);
      reg_rd(OFS_STAT, 8'h17);
      reg_rd(OFS_IRQF, 8'h80);
      reg_wr(OFS_IRQF, 8'h00);
      wait_irq(1'b0);
      seed = lfsr(seed);
      host_i.host_write(seed[7:0], 1'b0);
      wait_irq(1'b1);
      reg_rd(OFS_STAT, 8'h97);
      reg_rd(OFS_DATA, seed[7:0]);
      reg_rd(OFS_STAT, 8'h17);
      reg_wr(OFS_IRQF, 8'h00);
      wait_irq(1'b0);
    end
    $display("test transfers done");
    // Overrun keeps the unread byte; enable masks the request
    host_i.host_write(8'ha5, 1'b0);
    wait_irq(1'b1);
    repeat (4) @(posedge sys_clk);
    host_i.host_write(8'h3c, 1'b0);
    repeat (12) @(posedge sys_clk);
    reg_rd(OFS_STAT, 8'hb7);
    reg_rd(OFS_DATA, 8'ha5);
    reg_rd(OFS_STAT, 8'h37);
    reg_wr(OFS_IRQE, 8'h00);
    wait_irq(1'b0);
    reg_wr(OFS_IRQE, 8'h80);
    wait_irq(1'b1);
    reg_wr(OFS_STAT, 8'h17);
    reg_wr(OFS_IRQF, 8'h00);
    reg_rd(OFS_STAT, 8'h17);
    $display("test overrun done");
    // Deselected host is ignored
    host_i.host_write(8'h99, 1'b1);
    repeat (12) @(posedge sys_clk);
    reg_rd(OFS_STAT, 8'h17);
    reg_rd(OFS_IRQF, 8'h00);
    $display("test deselect done");
    // Mode off: full flags forced clear, overrun set by the status write, host ignored
    reg_wr(OFS_DATA, 8'h42);
    reg_wr(OFS_STAT, 8'h27);
    reg_rd(OFS_STAT, 8'h27);
    repeat (2) @(posedge sys_clk);
    cmp_lvl(8'hff, data_pin_oe);
    host_i.host_write(8'h66, 1'b0);
    repeat (12) @(posedge sys_clk);
    reg_rd(OFS_STAT, 8'h27);
    reg_rd(OFS_IRQF, 8'h00);
    reg_rd(OFS_DATA, 8'h42);
    reg_wr(OFS_STAT, 8'h25);
    repeat (2) @(posedge sys_clk);
    cmp_lvl(8'h02, {5'h00, ctl_pin_oe});
    $display("test mode_off done");
    repeat (4) @(posedge sys_clk);
    wrap_up();
  end
endmodule

`default_nettype wire
